// ==== common/mis_pkg.sv ====
/*
 * Constants for the metering interrupt and waveform-select block: register
 * offsets, field positions, reset values and divider figures.
 * Assumes a serial port front end that decodes register addresses.
 */
// Operation
// - Waveform register updates at master clock over 128, 256, 512 or 1024.
// - Mode bits 14:13 pick power, channel 1 or channel 2; 01 reserved.
// - Every interrupt event sets its status flag high.
// - A set flag with its enable bit drives the request output low.
// - Energy half-full flag sets on a rising energy register top bit.
// - Line dip flag sets on a voltage sag or missing zero crossings.
// - In calibration mode the line dip flag also marks integration end.
// - Waveform sample flag sets whenever the waveform register is loaded.
// - Status bit 4 follows the live zero-crossing state.
// - Temperature ready flag sets when a conversion result is available.
// - Energy overflow flag sets when the energy accumulator overflows.
// - Calibration mode bit 7 set to one enters calibration mode.
package mis_pkg;

    // Register bus geometry.
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned WAVE_W = 20;

    // Register offsets.
    localparam logic [4:0] OFS_FLAGS     = 5'h04;
    localparam logic [4:0] OFS_FLAGS_CLR = 5'h05;
    localparam logic [4:0] OFS_MODE      = 5'h06;
    localparam logic [4:0] OFS_ENABLES   = 5'h0a;

    // Reset values.
    localparam logic [15:0] MODE_RST    = 16'h0000;
    localparam logic [7:0]  ENABLES_RST = 8'h00;

    // Operating mode fields.
    localparam int unsigned MODE_CAL_BIT  = 7;
    localparam int unsigned MODE_RATE_LO  = 11;
    localparam int unsigned MODE_SRC_LO   = 13;
    localparam int unsigned MODE_TEST_BIT = 15;

    // Interrupt flag positions.
    localparam int unsigned FLG_HALF_FULL = 0;
    localparam int unsigned FLG_LINE_DIP  = 1;
    localparam int unsigned FLG_WAVE_SMP  = 3;
    localparam int unsigned FLG_ZERO_X    = 4;
    localparam int unsigned FLG_TEMP_RDY  = 5;
    localparam int unsigned FLG_OVERFLOW  = 7;
    localparam logic [7:0]  FLG_STICKY    = 8'hab;
    localparam logic [7:0]  FLG_RST       = 8'h00;

    // Waveform rate divider: the smallest ratio is 128, each code doubles it.
    localparam int unsigned RATE_DIV_W    = 10;
    localparam logic [9:0]  RATE_TC_128   = 10'h07f;
    localparam logic [9:0]  RATE_TC_256   = 10'h0ff;
    localparam logic [9:0]  RATE_TC_512   = 10'h1ff;
    localparam logic [9:0]  RATE_TC_1024  = 10'h3ff;

    typedef enum logic [1:0] {
        MIS_SRC_POWER = 2'b00,
        MIS_SRC_RSVD  = 2'b01,
        MIS_SRC_CH1   = 2'b10,
        MIS_SRC_CH2   = 2'b11
    } mis_src_t;

endpackage

// ==== common/mis_rate_if.sv ====
/*
 * Carrier between the top level and the waveform rate divider.
 * Assumes both ends run on clk_sys.
 */
`timescale 1ns/1ps
interface mis_rate_if;
    logic [1:0] rate_sel;
    logic       tick;

    modport ctrl (output rate_sel, input tick);
    modport div  (input rate_sel, output tick);
endinterface

// ==== rtl/mis_rate_div.sv ====
/*
 * Waveform rate divider: a one-cycle tick every 128, 256, 512 or 1024 clocks.
 * Assumes clk_sys is the master clock and rate_sel is stable between writes.
 */
`timescale 1ns/1ps
module mis_rate_div (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Rate select and tick
    mis_rate_if.div  rif
);

    logic [9:0] cnt_q;
    logic [9:0] term;

    always_comb begin
        case (rif.rate_sel)
            2'b00:   term = mis_pkg::RATE_TC_128;
            2'b01:   term = mis_pkg::RATE_TC_256;
            2'b10:   term = mis_pkg::RATE_TC_512;
            default: term = mis_pkg::RATE_TC_1024;
        endcase
    end

    // A ratio change takes effect at once; a count already past the new
    // terminal value is cleared to zero on the next clock, with no tick.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_q <= 10'h000;
        end else if (cnt_q >= term) begin
            cnt_q <= 10'h000;
        end else begin
            cnt_q <= cnt_q + 10'h001;
        end
    end

    assign rif.tick = (cnt_q == term);

endmodule

// ==== rtl/mis_irq_top.sv ====
/*
 * Interrupt flags, enables, request output and waveform source and rate
 * selection of the metering device.
 * Assumes the serial front end delivers decoded single-cycle register reads
 * and writes on clk_sys, and that all event inputs come from logic on clk_sys.
 * Assumes an outside pull-up on the request pin, which is only ever driven low.
 */
`timescale 1ns/1ps
module mis_irq_top (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Register access from the serial front end
    input  wire logic [4:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    output logic             reg_rvalid,
    // Event sources
    input  wire logic        energy_msb,
    input  wire logic        energy_ovf,
    input  wire logic        sag_evt,
    input  wire logic        no_zx_evt,
    input  wire logic        cal_end_evt,
    input  wire logic        zero_cross_state,
    input  wire logic        temp_done,
    // Waveform sources
    input  wire logic [19:0] power_lowpass_filter,
    input  wire logic [19:0] ch1_sample,
    input  wire logic [19:0] ch2_sample,
    output logic      [19:0] waveform_q,
    // Mode outputs
    output logic             calibration_mode,
    output logic             factory_test_mode,
    // Open-drain interrupt request
    output logic             irq_o,
    output logic             irq_oe_n
);

    logic [15:0] mode_q;
    logic [7:0]  enables_q;
    logic [7:0]  flags_q;
    logic [7:0]  flags_view;
    logic [7:0]  set_vec;
    logic [7:0]  clr_vec;
    logic        msb_q;
    logic        wave_load;
    logic        irq_oe_n_q;
    logic [15:0] rdata_q;
    logic        rvalid_q;
    logic [19:0] wave_q;
    logic [19:0] wave_sel;
    logic [1:0]  src_bits;
    logic [15:0] mode_d;
    logic [7:0]  enables_d;
    logic [7:0]  flags_d;
    logic [15:0] rdata_d;
    logic        irq_oe_n_d;
    logic        wr_mode;
    logic        wr_enables;
    logic        rd_clear;

    mis_pkg::mis_src_t src_sel;

    mis_rate_if rate_bus ();

    mis_rate_div u_rate_div (
        .clk_sys (clk_sys),
        .rst     (rst),
        .rif     (rate_bus)
    );

    assign rate_bus.rate_sel = mode_q[mis_pkg::MODE_RATE_LO +: 2];

    // Register strobes; the two status offsets are read-only and ignore writes.
    assign wr_mode    = reg_wr && (reg_addr == mis_pkg::OFS_MODE);
    assign wr_enables = reg_wr && (reg_addr == mis_pkg::OFS_ENABLES);
    assign rd_clear   = reg_rd && (reg_addr == mis_pkg::OFS_FLAGS_CLR);

    // Operating mode and enable registers.
    always_comb begin
        mode_d = mode_q;
        if (wr_mode) begin
            mode_d = reg_wdata;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mode_q <= mis_pkg::MODE_RST;
        end else begin
            mode_q <= mode_d;
        end
    end

    always_comb begin
        enables_d = enables_q;
        if (wr_enables) begin
            enables_d = reg_wdata[7:0];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            enables_q <= mis_pkg::ENABLES_RST;
        end else begin
            enables_q <= enables_d;
        end
    end

    assign calibration_mode  = mode_q[mis_pkg::MODE_CAL_BIT];
    // The test setting is only reported outward; the host must keep it clear.
    assign factory_test_mode = mode_q[mis_pkg::MODE_TEST_BIT];

    // Waveform source selection.
    assign src_bits = mode_q[mis_pkg::MODE_SRC_LO +: 2];
    assign src_sel  = mis_pkg::mis_src_t'(src_bits);

    always_comb begin
        case (src_sel)
            mis_pkg::MIS_SRC_POWER: wave_sel = power_lowpass_filter;
            mis_pkg::MIS_SRC_CH1:   wave_sel = ch1_sample;
            mis_pkg::MIS_SRC_CH2:   wave_sel = ch2_sample;
            default:                wave_sel = wave_q;
        endcase
    end

    // The reserved source code freezes the register, so no sample flag is
    // raised for data that did not change.
    assign wave_load = rate_bus.tick && (src_sel != mis_pkg::MIS_SRC_RSVD);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wave_q <= 20'h00000;
        end else if (wave_load) begin
            wave_q <= wave_sel;
        end
    end

    assign waveform_q = wave_q;

    // Edge detect of the energy register top bit.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            msb_q <= 1'b0;
        end else begin
            msb_q <= energy_msb;
        end
    end

    // Event set vector; bit 4 is live and never latched.
    always_comb begin
        set_vec = 8'h00;
        set_vec[mis_pkg::FLG_HALF_FULL] = energy_msb && !msb_q;
        set_vec[mis_pkg::FLG_LINE_DIP]  = sag_evt || no_zx_evt
                                          || (calibration_mode && cal_end_evt);
        set_vec[mis_pkg::FLG_WAVE_SMP]  = wave_load;
        set_vec[mis_pkg::FLG_TEMP_RDY]  = temp_done;
        set_vec[mis_pkg::FLG_OVERFLOW]  = energy_ovf;
    end

    // Only the flags seen by the clearing read are cleared.
    assign clr_vec = rd_clear ? flags_q : 8'h00;

    // A new event in the clearing cycle survives because set wins.
    always_comb begin
        flags_d = flags_q & ~clr_vec;
        flags_d = flags_d | set_vec;
        flags_d = flags_d & mis_pkg::FLG_STICKY;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            flags_q <= mis_pkg::FLG_RST;
        end else begin
            flags_q <= flags_d;
        end
    end

    always_comb begin
        flags_view = flags_q;
        flags_view[mis_pkg::FLG_ZERO_X] = zero_cross_state;
    end

    // Request pin: driven low while any enabled flag stands.
    assign irq_oe_n_d = ~(|(flags_view & enables_q));

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq_oe_n_q <= 1'b1;
        end else begin
            irq_oe_n_q <= irq_oe_n_d;
        end
    end

    assign irq_o    = 1'b0;
    assign irq_oe_n = irq_oe_n_q;

    // Register read path, one cycle after the strobe.
    always_comb begin
        case (reg_addr)
            mis_pkg::OFS_FLAGS:     rdata_d = {8'h00, flags_view};
            mis_pkg::OFS_FLAGS_CLR: rdata_d = {8'h00, flags_view};
            mis_pkg::OFS_MODE:      rdata_d = mode_q;
            mis_pkg::OFS_ENABLES:   rdata_d = {8'h00, enables_q};
            default:                rdata_d = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_q <= 16'h0000;
        end else if (reg_rd) begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= reg_rd;
        end
    end

    assign reg_rdata  = rdata_q;
    assign reg_rvalid = rvalid_q;

endmodule

// ==== tb/mis_sva.sv ====
/* Port checker for mis_irq_top.
   Assumes the bind at the foot of this file. */
`timescale 1ns/1ps
module mis_sva (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rst,
    // Register access
    input wire logic [4:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic        reg_rvalid,
    // Events and outputs
    input wire logic        sag_evt,
    input wire logic        temp_done,
    input wire logic        zero_cross_state,
    input wire logic [19:0] waveform_q,
    input wire logic        calibration_mode,
    input wire logic        irq_o,
    input wire logic        irq_oe_n
);
    logic [7:0] irq_en_q;
    // Mirror of the enable register, kept from the writes seen on the bus.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq_en_q <= 8'h00;
        end else if (reg_wr && reg_addr == mis_pkg::OFS_ENABLES) begin
            irq_en_q <= reg_wdata[7:0];
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Both status offsets return the same flags.
    sequence rd_flags;
        reg_rd && reg_addr[4:1] == 4'h2;
    endsequence
    // No read in between, so no clear can hide the flag.
    sequence quiet;
        (!reg_rd) [*2];
    endsequence
    rvalid_follows_a: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    sag_flag_a: assert property (sag_evt ##1 quiet ##1 rd_flags |=> reg_rdata[1])
        else $error("line dip flag missing");
    temp_flag_a: assert property (temp_done ##1 quiet ##1 rd_flags |=> reg_rdata[5])
        else $error("temperature flag missing");
    zx_live_a: assert property (rd_flags |=> reg_rdata[4] == $past(zero_cross_state))
        else $error("zero cross bit wrong");
    unused_zero_a: assert property (rd_flags |=> reg_rdata[15:8] == 8'h00 && !reg_rdata[2])
        else $error("unused status bits set");
    wave_hold_a: assert property ($changed(waveform_q) |=> $stable(waveform_q) [*8])
        else $error("waveform updated too often");
    cal_mode_a: assert property (reg_wr && reg_addr == 5'h06 |=>
        calibration_mode == $past(reg_wdata[7]))
        else $error("calibration mode not taken");
    irq_data_a: assert property ($fell(irq_oe_n) |-> !irq_o && $past(irq_en_q) != 8'h00)
        else $error("request driven with no enable");
    irq_follow_a: assert property (rd_flags |=>
        irq_oe_n == ~|(reg_rdata[7:0] & $past(irq_en_q)))
        else $error("request pin does not follow flags");
endmodule
bind mis_irq_top mis_sva u_mis_sva (.clk_sys, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .reg_rvalid, .sag_evt, .temp_done, .zero_cross_state, .waveform_q,
    .calibration_mode, .irq_o, .irq_oe_n);

// ==== tb/mis_host.sv ====
/* Host model: register reads and writes toward the device.
   Assumes the device answers a read one cycle after taking it. */
`timescale 1ns/1ps
module mis_host (
    // Clock
    input wire logic         clk_sys,
    // Register access
    output logic      [4:0]  reg_addr,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic      [15:0] reg_wdata,
    input  wire logic [15:0] reg_rdata
);
    initial begin
        reg_addr = 5'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0000;
    end
    task automatic wr(input logic [4:0] a, input logic [15:0] dv);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= (a == 5'h06) ? (dv & 16'h7fff) : dv;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_wdata <= ~dv;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] dv);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
        dv = reg_rdata;
    endtask
    // Plain status first, then the clearing copy.
    task automatic svc(output logic [15:0] dv);
        rd(5'h04, dv);
        rd(5'h05, dv);
    endtask
endmodule

// ==== tb/mis_irq_top_test.sv ====
/* Bench for mis_irq_top with a host model on its register port.
   Assumes the checker is bound to the design. */
`timescale 1ns/1ps
module mis_irq_top_test;
    logic        clk_sys, rst, reg_wr, reg_rd, reg_rvalid, irq_o, irq_oe_n;
    logic [4:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic        energy_msb, energy_ovf, sag_evt, no_zx_evt, cal_end_evt, temp_done;
    logic        zero_cross_state, calibration_mode, factory_test_mode;
    logic [19:0] power_lowpass_filter, ch1_sample, ch2_sample, waveform_q, w, v;
    logic [7:0]  ebit [6] = '{8'h01, 8'h02, 8'h02, 8'h20, 8'h80, 8'h02};
    int          errors = 0;
    int          checked = 0;
    // Open-drain request with a pull-up.
    wire         irq_n_pin = irq_oe_n ? 1'b1 : irq_o;
    mis_irq_top u_mis_irq_top (.clk_sys, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
        .reg_rdata, .reg_rvalid, .energy_msb, .energy_ovf, .sag_evt, .no_zx_evt,
        .cal_end_evt, .zero_cross_state, .temp_done, .power_lowpass_filter, .ch1_sample,
        .ch2_sample, .waveform_q, .calibration_mode, .factory_test_mode, .irq_o, .irq_oe_n);
    mis_host u_mis_host (.clk_sys, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata);
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic step();
        @(posedge clk_sys);
        #1;
    endtask
    task automatic fire(input int k);
        @(posedge clk_sys);
        case (k)
            0: energy_msb <= 1'b1;
            1: sag_evt <= 1'b1;
            2: no_zx_evt <= 1'b1;
            3: temp_done <= 1'b1;
            4: energy_ovf <= 1'b1;
            default: cal_end_evt <= 1'b1;
        endcase
        @(posedge clk_sys);
        {energy_msb, sag_evt, no_zx_evt, temp_done, energy_ovf, cal_end_evt} <= 6'h00;
    endtask
    // A fixed source or a frozen one gives no change: the wait is bounded.
    task automatic wchg(output logic [19:0] r);
        logic [19:0] o;
        o = waveform_q;
        for (int i = 0; i < 2100 && waveform_q === o; i++) begin
            @(posedge clk_sys);
            #1;
        end
        r = waveform_q;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        #(25000 * 8);
        errors++;
        tally_and_finish();
    end
    always @(posedge clk_sys) ch1_sample <= rst ? 20'h00000 : ch1_sample + 20'h00001;
    initial begin
        rst = 1'b1;
        {energy_msb, energy_ovf, sag_evt, no_zx_evt, cal_end_evt, temp_done} = 6'h00;
        zero_cross_state = 1'b0;
        power_lowpass_filter = 20'h0abcd;
        ch2_sample = 20'h12345;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        u_mis_host.rd(5'h04, d);
        chk(d, 20'h00000);
        u_mis_host.rd(5'h1f, d);
        chk(d, 20'h00000);
        chk(irq_n_pin, 20'h00001);
        $display("reset test done");
        u_mis_host.wr(5'h06, 16'h2000);
        u_mis_host.wr(5'h0a, 16'h00ff);
        u_mis_host.rd(5'h06, d);
        chk(d, 20'h02000);
        u_mis_host.rd(5'h0a, d);
        chk(d, 20'h000ff);
        for (int k = 0; k < 5; k++) begin
            fire(k);
            step();
            chk(irq_n_pin, 20'h00000);
            u_mis_host.svc(d);
            chk(d, {12'h000, ebit[k]});
            step();
            chk(irq_n_pin, 20'h00001);
            u_mis_host.rd(5'h04, d);
            chk(d, 20'h00000);
        end
        $display("event test done");
        u_mis_host.wr(5'h0a, 16'h0000);
        fire(5);
        step();
        chk(irq_n_pin, 20'h00001);
        u_mis_host.rd(5'h05, d);
        chk(d, 20'h00000);
        fire(1);
        step();
        chk(irq_n_pin, 20'h00001);
        u_mis_host.rd(5'h05, d);
        chk(d, 20'h00002);
        u_mis_host.wr(5'h06, 16'ha080);
        step();
        chk(factory_test_mode, 20'h00000);
        chk(calibration_mode, 20'h00001);
        fire(5);
        u_mis_host.rd(5'h05, d);
        chk(d, 20'h00002);
        zero_cross_state <= 1'b1;
        u_mis_host.rd(5'h05, d);
        chk(d, 20'h00010);
        zero_cross_state <= 1'b0;
        u_mis_host.rd(5'h05, d);
        chk(d, 20'h00000);
        $display("mode test done");
        for (int s = 0; s < 2; s++) begin
            u_mis_host.wr(5'h06, s ? 16'h6000 : 16'h0000);
            u_mis_host.rd(5'h05, d);
            wchg(w);
            chk(w, s ? ch2_sample : power_lowpass_filter);
            u_mis_host.rd(5'h05, d);
            chk(d, 20'h00008);
        end
        for (int c = 0; c < 4; c++) begin
            u_mis_host.wr(5'h06, {3'h2, c[1:0], 11'h000});
            wchg(w);
            wchg(w);
            wchg(v);
            chk(v - w, 20'h00080 << c);
        end
        u_mis_host.wr(5'h06, 16'h2000);
        u_mis_host.rd(5'h05, d);
        w = waveform_q;
        wchg(v);
        chk(v, w);
        u_mis_host.rd(5'h05, d);
        chk(d, 20'h00000);
        $display("waveform test done");
        tally_and_finish();
    end
endmodule
